// file: hdl/itu_consts.svh
/*
  constants of the interrupt-triggered transfer unit: descriptor layout,
  field positions, reset values and counts.
  assumes: included by bare name from the package and the testbench.
*/
`ifndef ITU_CONSTS_SVH
`define ITU_CONSTS_SVH
// ==========================================================
// descriptor words, 16 bytes per channel
`define ITU_DESC_STRIDE 32'h0000_0010
`define ITU_W_MODE      2'h0
`define ITU_W_SRC       2'h1
`define ITU_W_DST       2'h2
`define ITU_W_CNT       2'h3
// ==========================================================
// mode word fields
`define ITU_F_MD        0
`define ITU_F_SZ        2
`define ITU_F_CHAIN     4
`define ITU_F_CHZERO    5
`define ITU_F_IEACH     6
`define ITU_F_SINC      7
`define ITU_F_DINC      8
`define ITU_F_SHORT     9
`define ITU_F_PASS      10
`define ITU_F_RSKIP     11
`define ITU_F_RSIDE     12
// ==========================================================
// count word fields and limits
`define ITU_C_REM       0
`define ITU_C_RLD       8
`define ITU_C_TOT       16
`define ITU_RPT_MAX     9'h100
`define ITU_SHORT_MSB   23
`define ITU_SRC_COUNT   129
`define ITU_IDX_W       8
`define ITU_RST_WORD    32'h0000_0000
`endif

// file: hdl/itu_pkg.sv
/*
  types of the interrupt-triggered transfer unit.
  assumes: itu_consts.svh on the include path.
*/
`include "itu_consts.svh"
package itu_pkg;
  // ==========================================================
  // enumerations
  typedef enum logic [2:0] {
    ITU_IDLE  = 3'b000,
    ITU_FETCH = 3'b001,
    ITU_RD    = 3'b010,
    ITU_WR    = 3'b011,
    ITU_WBACK = 3'b100,
    ITU_FIN   = 3'b101
  } itu_state_e;
  typedef enum logic [1:0] {
    ITU_NORMAL = 2'b00,
    ITU_REPEAT = 2'b01,
    ITU_BLOCK  = 2'b10
  } itu_mode_e;
  // ==========================================================
  // one memory access
  typedef struct packed {
    logic        req;
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } itu_acc_s;
  // ==========================================================
  // engine state
  typedef struct packed {
    itu_state_e               st;
    logic [1:0]               word;
    logic [`ITU_IDX_W-1:0]    ch;
    logic [31:0]              daddr;
    logic [31:0]              mode;
    logic [31:0]              src;
    logic [31:0]              dst;
    logic [31:0]              cnt;
    logic                     last;
    logic                     chd;
    logic                     held_v;
    logic [`ITU_IDX_W-1:0]    held_ch;
    itu_acc_s                 acc;
    logic                     ev;
    logic                     irq;
    logic                     clr;
    logic                     busy;
    logic                     stop_ack;
  } itu_eng_s;
endpackage : itu_pkg

// file: hdl/itu_buf2.sv
/*
  two-entry data buffer with valid and ready on both sides.
  assumes: one clock, asynchronous active-low reset already synchronised.
*/
`timescale 1ns/1ps
module itu_buf2
  import itu_pkg::*;
#(
  parameter int W = 32
)(
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  typedef struct packed {
    logic [1:0][W-1:0] slot;
    logic              wp;
    logic              rp;
    logic [1:0]        cnt;
  } itu_buf_s;
  itu_buf_s r;
  itu_buf_s next_r;
  logic     push;
  logic     pop;
  // ==========================================================
  // occupancy
  always_comb
  begin
    next_r = r;
    push   = in_valid && (r.cnt != 2'h2);
    pop    = out_ready && (r.cnt != 2'h0);
    if (push)
    begin
      next_r.slot[r.wp] = in_data;
      next_r.wp         = ~r.wp;
    end
    if (pop)
      next_r.rp = ~r.rp;
    next_r.cnt = r.cnt + {1'b0, push} - {1'b0, pop};
  end
  assign in_ready  = (r.cnt != 2'h2);
  assign out_valid = (r.cnt != 2'h0);
  assign out_data  = r.slot[r.rp];
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else if (ce)
      r <= next_r;
  end
  // ==========================================================
  // checks
  a_buf_bound: assert property (@(posedge ref_clk) disable iff (!rst_n)
    r.cnt != 2'h3) else $error("buffer count out of range");
  a_buf_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("buffer head lost while stalled");
endmodule : itu_buf2

// file: hdl/itu_pick.sv
/*
  fixed-priority picker over enabled activation requests.
  assumes: requests are levels synchronous to the clock.
*/
`timescale 1ns/1ps
module itu_pick
  import itu_pkg::*;
#(
  parameter int N = `ITU_SRC_COUNT,
  parameter int W = `ITU_IDX_W
)(
  input  wire logic [N-1:0] req,
  input  wire logic [N-1:0] en,
  output logic              valid,
  output logic [W-1:0]      idx
);
  // ==========================================================
  // lowest index wins
  always_comb
  begin
    valid = 1'b0;
    idx   = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i] && en[i])
      begin
        valid = 1'b1;
        idx   = W'(i);
      end
    end
  end
endmodule : itu_pick

// file: hdl/itu_engine.sv
/*
  interrupt-triggered transfer unit: activation, descriptor fetch, data
  move through a two-entry buffer, write-back, chaining and signalling.
  assumes: memory answers mem_req with a one-cycle mem_ack; a source drops
  its request the cycle after req_clr or enable_clr names it.
*/
// Behaviour
// - normal mode moves one unit per request
// - repeat mode reloads address after repeat count
// - repeat count up to 256 units
// - block mode moves whole block per request
// - block length one to 256 units
// - one descriptor channel per enabled source
// - chaining runs next descriptor in same activation
// - chain always or only at count zero
// - short mode sign-extends 24-bit addresses
// - full mode uses full 32-bit addresses
// - unit is byte, word or longword
// - request may pass through to cpu
// - cpu interrupt after each transfer optionally
// - cpu interrupt when total count completes
// - event pulse per unit or per block
// - repeated channel may skip descriptor read
// - fixed address skips its write-back
// - module stop refuses activations
// - only enabled sources activate the unit
// - up to 129 activation sources
`timescale 1ns/1ps
module itu_engine
  import itu_pkg::*;
#(
  parameter int          N_SRC     = `ITU_SRC_COUNT,
  parameter logic [31:0] DESC_BASE = 32'h0000_0000
)(
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  input  wire logic                  ce,
  input  wire logic                  module_stop,
  input  wire logic [N_SRC-1:0]      req_in,
  input  wire logic [N_SRC-1:0]      transfer_request_enable_bits,
  output logic                       mem_req,
  output logic                       mem_we,
  output logic [1:0]                 mem_size,
  output logic [31:0]                mem_addr,
  output logic [31:0]                mem_wdata,
  input  wire logic                  mem_ack,
  input  wire logic [31:0]           mem_rdata,
  output logic                       cpu_irq,
  output logic                       req_clr,
  output logic                       enable_clr,
  output logic [`ITU_IDX_W-1:0]      act_src,
  output logic                       event_link,
  output logic                       busy,
  output logic                       stop_ack
);
  // ==========================================================
  // reset release
  logic     rs1;
  logic     rst_n;
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rs1   <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rs1   <= 1'b1;
      rst_n <= rs1;
    end
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] unit_step(input logic [1:0] sz);
    unique case (sz)
      2'b00:   unit_step = 32'h0000_0001;
      2'b01:   unit_step = 32'h0000_0002;
      default: unit_step = 32'h0000_0004;
    endcase
  endfunction : unit_step
  function automatic logic [31:0] fit(input logic [31:0] d,
                                      input logic [1:0]  sz);
    unique case (sz)
      2'b00:   fit = {24'h00_0000, d[7:0]};
      2'b01:   fit = {16'h0000, d[15:0]};
      default: fit = d;
    endcase
  endfunction : fit
  function automatic logic [31:0] eff(input logic [31:0] a,
                                      input logic        short);
    eff = short ? {{8{a[`ITU_SHORT_MSB]}}, a[`ITU_SHORT_MSB:0]} : a;
  endfunction : eff
  function automatic itu_acc_s acc(input logic        we,
                                   input logic [1:0]  sz,
                                   input logic [31:0] a,
                                   input logic [31:0] d);
    acc = '{req: 1'b1, we: we, size: sz, addr: a, wdata: d};
  endfunction : acc
  // ==========================================================
  // state and submodules
  itu_eng_s              r;
  itu_eng_s              next_r;
  logic                  pick_v;
  logic [`ITU_IDX_W-1:0] pick_i;
  logic                  b_in_valid;
  logic                  b_in_ready;
  logic                  b_out_valid;
  logic [31:0]           b_out_data;
  logic                  b_out_ready;
  logic                  ack;
  itu_mode_e             md;
  logic [1:0]            sz;
  logic [31:0]           step;
  logic [31:0]           back;
  logic                  rem_done;
  logic                  chain_go;
  itu_pick #(.N(N_SRC), .W(`ITU_IDX_W)) u_pick (
    .req   (req_in),
    .en    (transfer_request_enable_bits),
    .valid (pick_v),
    .idx   (pick_i)
  );
  // data words pass the buffer so a slow write side loses nothing
  itu_buf2 #(.W(32)) u_buf (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_valid  (b_in_valid),
    .in_data   (fit(mem_rdata, sz)),
    .in_ready  (b_in_ready),
    .out_valid (b_out_valid),
    .out_data  (b_out_data),
    .out_ready (b_out_ready)
  );
  assign ack         = r.acc.req && mem_ack;
  assign md          = itu_mode_e'(r.mode[`ITU_F_MD +: 2]);
  assign sz          = r.mode[`ITU_F_SZ +: 2];
  assign step        = unit_step(sz);
  assign rem_done    = (r.cnt[`ITU_C_REM +: 8] == 8'h01);
  assign b_in_valid  = ack && (r.st == ITU_RD);
  assign b_out_ready = ack && (r.st == ITU_WR);
  // zero reload field means 256 units
  assign back = (r.cnt[`ITU_C_RLD +: 8] == 8'h00) ?
                (32'(`ITU_RPT_MAX) << sz) :
                (32'(r.cnt[`ITU_C_RLD +: 8]) << sz);
  assign chain_go = r.mode[`ITU_F_CHAIN] &&
                    (!r.mode[`ITU_F_CHZERO] || r.last);
  // ==========================================================
  // next state
  always_comb
  begin
    next_r          = r;
    next_r.ev       = 1'b0;
    next_r.irq      = 1'b0;
    next_r.clr      = 1'b0;
    next_r.stop_ack = module_stop && (r.st == ITU_IDLE);
    next_r.busy     = (r.st != ITU_IDLE);
    if (ack)
      next_r.acc.req = 1'b0;
    unique case (r.st)
      ITU_IDLE:
      begin
        // no activation while stopped; wait out a clear pulse
        if (!module_stop && pick_v && !r.clr && !r.irq)
        begin
          next_r.ch    = pick_i;
          next_r.daddr = DESC_BASE + (32'(pick_i) << 4);
          next_r.chd   = 1'b0;
          next_r.last  = 1'b0;
          next_r.busy  = 1'b1;
          if (r.held_v && r.held_ch == pick_i && r.mode[`ITU_F_RSKIP])
            next_r.st = ITU_RD;
          else
          begin
            next_r.st   = ITU_FETCH;
            next_r.word = `ITU_W_MODE;
            next_r.acc  = acc(1'b0, 2'b10,
                              DESC_BASE + (32'(pick_i) << 4), 32'h0);
          end
        end
      end
      ITU_FETCH:
      begin
        if (ack)
        begin
          unique case (r.word)
            `ITU_W_MODE: next_r.mode = mem_rdata;
            `ITU_W_SRC:  next_r.src  = mem_rdata;
            `ITU_W_DST:  next_r.dst  = mem_rdata;
            `ITU_W_CNT:  next_r.cnt  = mem_rdata;
          endcase
          if (r.word == `ITU_W_CNT)
            next_r.st = ITU_RD;
          else
          begin
            next_r.word = r.word + 2'h1;
            next_r.acc  = acc(1'b0, 2'b10,
                              r.daddr + {28'h0, r.word + 2'h1, 2'b00}, 32'h0);
          end
        end
      end
      ITU_RD:
      begin
        if (ack)
          next_r.st = ITU_WR;
        else if (!r.acc.req && b_in_ready)
          next_r.acc = acc(1'b0, sz, eff(r.src, r.mode[`ITU_F_SHORT]),
                           32'h0);
      end
      ITU_WR:
      begin
        if (ack)
        begin
          if (r.mode[`ITU_F_SINC])
            next_r.src = r.src + step;
          if (r.mode[`ITU_F_DINC])
            next_r.dst = r.dst + step;
          next_r.st = ITU_WBACK;
          if (md == ITU_NORMAL)
          begin
            next_r.cnt[`ITU_C_TOT +: 16] = r.cnt[`ITU_C_TOT +: 16] - 16'h1;
            next_r.last = (r.cnt[`ITU_C_TOT +: 16] == 16'h0001);
            next_r.ev   = 1'b1;
          end
          else
          begin
            next_r.cnt[`ITU_C_REM +: 8] = rem_done ?
              r.cnt[`ITU_C_RLD +: 8] : r.cnt[`ITU_C_REM +: 8] - 8'h1;
            if (rem_done && r.mode[`ITU_F_RSIDE] && r.mode[`ITU_F_DINC])
              next_r.dst = r.dst + step - back;
            if (rem_done && !r.mode[`ITU_F_RSIDE] && r.mode[`ITU_F_SINC])
              next_r.src = r.src + step - back;
            // event per unit, or per block
            next_r.ev = (md == ITU_REPEAT) || rem_done;
            if (md == ITU_BLOCK)
            begin
              if (rem_done)
              begin
                next_r.cnt[`ITU_C_TOT +: 16] =
                  r.cnt[`ITU_C_TOT +: 16] - 16'h1;
                next_r.last = (r.cnt[`ITU_C_TOT +: 16] == 16'h0001);
              end
              else
                next_r.st = ITU_RD;
            end
          end
          if (next_r.st == ITU_WBACK)
          begin
            // fixed addresses are not written back
            next_r.word = r.mode[`ITU_F_SINC] ? `ITU_W_SRC :
                          r.mode[`ITU_F_DINC] ? `ITU_W_DST : `ITU_W_CNT;
          end
        end
        else if (!r.acc.req && b_out_valid)
          next_r.acc = acc(1'b1, sz, eff(r.dst, r.mode[`ITU_F_SHORT]),
                           b_out_data);
      end
      ITU_WBACK:
      begin
        if (ack)
        begin
          if (r.word == `ITU_W_CNT)
            next_r.st = ITU_FIN;
          else
            next_r.word = (r.word == `ITU_W_SRC && r.mode[`ITU_F_DINC]) ?
                          `ITU_W_DST : `ITU_W_CNT;
        end
        else if (!r.acc.req)
          next_r.acc = acc(1'b1, 2'b10,
                           r.daddr + {28'h0, r.word, 2'b00},
                           (r.word == `ITU_W_SRC) ? r.src :
                           (r.word == `ITU_W_DST) ? r.dst : r.cnt);
      end
      ITU_FIN:
      begin
        if (chain_go)
        begin
          // next descriptor in the same activation
          next_r.daddr = r.daddr + `ITU_DESC_STRIDE;
          next_r.chd   = 1'b1;
          next_r.last  = 1'b0;
          next_r.word  = `ITU_W_MODE;
          next_r.st    = ITU_FETCH;
          next_r.acc   = acc(1'b0, 2'b10, r.daddr + `ITU_DESC_STRIDE, 32'h0);
        end
        else
        begin
          next_r.st      = ITU_IDLE;
          next_r.held_v  = !r.chd;
          next_r.held_ch = r.ch;
          if (r.mode[`ITU_F_PASS] || r.mode[`ITU_F_IEACH] || r.last)
            next_r.irq = 1'b1;
          else
            next_r.clr = 1'b1;
        end
      end
      default:
        next_r.st = ITU_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else if (ce)
      r <= next_r;
  end
  // ==========================================================
  // outputs
  assign mem_req    = r.acc.req;
  assign mem_we     = r.acc.we;
  assign mem_size   = r.acc.size;
  assign mem_addr   = r.acc.addr;
  assign mem_wdata  = r.acc.wdata;
  assign cpu_irq    = r.irq;
  assign req_clr    = r.clr;
  assign enable_clr = r.irq;
  assign act_src    = r.ch;
  assign event_link = r.ev;
  assign busy       = r.busy;
  assign stop_ack   = r.stop_ack;
  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_normal_one: assert property (
    ce && r.st == ITU_WR && ack && md == ITU_NORMAL |=> r.st == ITU_WBACK)
    else $error("normal mode moved more than one unit");
  a_repeat_reload: assert property (
    ce && r.st == ITU_WR && ack && md == ITU_REPEAT && rem_done
    |=> r.cnt[`ITU_C_REM +: 8] == $past(r.cnt[`ITU_C_RLD +: 8]))
    else $error("repeat counter not reloaded");
  a_block_cont: assert property (
    ce && r.st == ITU_WR && ack && md == ITU_BLOCK && !rem_done
    |=> r.st == ITU_RD && !r.ev)
    else $error("block stopped early");
  a_short_addr: assert property (
    r.acc.req && r.st == ITU_RD && r.mode[`ITU_F_SHORT]
    |-> r.acc.addr[31:23] == {9{r.acc.addr[23]}})
    else $error("short address not sign extended");
  a_event_pulse: assert property (
    ce && r.ev |=> !r.ev)
    else $error("event link longer than one cycle");
  a_stop_refuse: assert property (
    ce && module_stop && r.st == ITU_IDLE |=> r.st == ITU_IDLE)
    else $error("activation taken while stopped");
  a_clear_cpu: assert property (
    r.clr |-> !r.irq && r.st == ITU_IDLE)
    else $error("request cleared and passed at once");
  a_wb_skip: assert property (
    r.acc.req && r.acc.we && r.st == ITU_WBACK
    && r.word == `ITU_W_SRC |-> r.mode[`ITU_F_SINC])
    else $error("fixed source written back");
  a_req_hold: assert property (
    ce && r.acc.req && !mem_ack |=> r.acc.req && $stable(r.acc.addr))
    else $error("memory request dropped before answer");
  c_chain: cover property (r.st == ITU_FIN && chain_go);
  c_rskip: cover property (r.st == ITU_IDLE ##1 r.st == ITU_RD);
  c_block_done: cover property (r.ev && md == ITU_BLOCK);
  c_last_irq: cover property (r.irq && r.last);
endmodule : itu_engine

// file: sim/itu_mem_model.sv
/*
  memory model on the far side of the transfer unit's memory bus.
  assumes: one access at a time, mem_req held until mem_ack.
*/
`timescale 1ns/1ps
module itu_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [1:0]  mem_size,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  logic [31:0] m [0:127];
  logic [1:0]  wt;
  logic [6:0]  ix;
  logic [4:0]  sh;
  logic [31:0] mk;
  assign ix = mem_addr[8:2];
  assign sh = {mem_addr[1:0], 3'h0};
  assign mk = (mem_size == 2'h0) ? 32'h0000_00ff :
              (mem_size == 2'h1) ? 32'h0000_ffff : 32'hffff_ffff;
  initial
  begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    wt = 2'h0;
  end
  // ==========================================================
  // answer after one or three cycles, one-cycle ack
  always @(posedge ref_clk)
  begin
    mem_ack <= 1'b0;
    // idle read data toggles so a stale sample never matches
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack)
    begin
      if (wt != (slow ? 2'h2 : 2'h0))
        wt <= wt + 2'h1;
      else
      begin
        wt <= 2'h0;
        mem_ack <= 1'b1;
        if (mem_we)
          m[ix] <= (m[ix] & ~(mk << sh)) | ((mem_wdata & mk) << sh);
        else
          mem_rdata <= (m[ix] >> sh) & mk;
      end
    end
  end
endmodule : itu_mem_model

// file: sim/test_interrupt_triggered_transfer_unit.sv
/*
  testbench of the transfer unit: descriptors preloaded in the model,
  requests raised per channel, results read back from memory.
  assumes: DESC_BASE 0, sources drop a request after its clear pulse.
*/
`timescale 1ns/1ps
`include "itu_consts.svh"
module test_interrupt_triggered_transfer_unit;
  import itu_pkg::*;
  localparam int NS = `ITU_SRC_COUNT;
  logic ref_clk, resetn, ce, module_stop, slow, seen_hi, seen_full;
  logic [NS-1:0] req_in, en;
  logic mem_req, mem_we, mem_ack, cpu_irq, req_clr, enable_clr;
  logic event_link, busy, stop_ack;
  logic [1:0]  mem_size;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, watch;
  logic [7:0]  act_src;
  int n_errors, check_count, n_ev, n_irq, n_clr, n_rd0, n_wsrc;

  itu_engine #(.N_SRC(NS)) dut (.ref_clk(ref_clk), .resetn(resetn),
    .ce(ce), .module_stop(module_stop), .req_in(req_in),
    .transfer_request_enable_bits(en), .mem_req(mem_req),
    .mem_we(mem_we), .mem_size(mem_size), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .cpu_irq(cpu_irq), .req_clr(req_clr), .enable_clr(enable_clr),
    .act_src(act_src), .event_link(event_link), .busy(busy),
    .stop_ack(stop_ack));
  itu_mem_model far (.ref_clk(ref_clk), .slow(slow), .mem_req(mem_req),
    .mem_we(mem_we), .mem_size(mem_size), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // monitor and request sources
  always @(posedge ref_clk)
  begin
    if (event_link === 1'b1) n_ev++;
    if (cpu_irq === 1'b1) n_irq++;
    if (req_clr === 1'b1) n_clr++;
    if (mem_req && mem_ack && !mem_we && mem_addr == watch) n_rd0++;
    if (mem_req && mem_ack && mem_we && mem_addr == watch + 4) n_wsrc++;
    if (mem_req === 1'b1 && mem_addr === 32'hffff_fff3) seen_hi <= 1'b1;
    if (mem_req === 1'b1 && mem_addr === 32'h00ff_ffe2) seen_full <= 1'b1;
    // source drops its request one cycle after the clear pulse
    if (req_clr === 1'b1 || enable_clr === 1'b1) req_in[act_src] <= 1'b0;
    if (enable_clr === 1'b1) en[act_src] <= 1'b0;
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic desc(input int ch, input logic [31:0] md, s, d, c);
    far.m[ch*4] = md;
    far.m[ch*4+1] = s;
    far.m[ch*4+2] = d;
    far.m[ch*4+3] = c;
  endtask : desc

  task automatic wait_done();
    int k;
    k = 0;
    while (!(req_clr === 1'b1 || cpu_irq === 1'b1) && k < 400)
    begin
      @(negedge ref_clk);
      k++;
    end
    chk("completion", k < 400, 1'b1);
    repeat (4) @(negedge ref_clk);
  endtask : wait_done

  task automatic fire(input int ch);
    n_ev = 0;
    n_irq = 0;
    n_clr = 0;
    @(posedge ref_clk);
    req_in[ch] <= 1'b1;
    wait_done();
  endtask : fire

  initial
  begin
    #100us;
    n_errors++;
    end_of_test();
  end

  initial
  begin
    resetn = 1'b0; ce = 1'b1; module_stop = 1'b0; slow = 1'b0;
    req_in = '0; en = '0; watch = 32'h0; seen_hi = 1'b0; seen_full = 1'b0;
    n_errors = 0; check_count = 0; n_rd0 = 0; n_wsrc = 0;
    for (int i = 0; i < 128; i++) far.m[i] = 32'h0;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    // ==========================================================
    // disabled source and module stop hold a request off
    desc(3, 32'h0000_0188, 32'h0000_0100, 32'h0000_0180, 32'h0002_0000);
    far.m[64] = 32'ha5a5_0001;
    n_ev = 0; n_irq = 0; n_clr = 0;
    req_in[3] <= 1'b1;
    repeat (30) @(negedge ref_clk);
    chk("busy off", busy, 1'b0);
    @(posedge ref_clk);
    module_stop <= 1'b1;
    en <= '1;
    repeat (30) @(negedge ref_clk);
    chk("stop ack", stop_ack, 1'b1);
    chk("busy stop", busy, 1'b0);
    chk("stop clr", n_clr, 32'h0);
    @(posedge ref_clk);
    module_stop <= 1'b0;
    wait_done();
    // ==========================================================
    // normal longword with incrementing sides
    chk("n data", far.m[96], 32'ha5a5_0001);
    chk("n src", far.m[13], 32'h0000_0104);
    chk("n dst", far.m[14], 32'h0000_0184);
    chk("n total", far.m[15][31:16], 32'h1);
    chk("n ev", n_ev, 32'h1);
    chk("n clr", n_clr, 32'h1);
    chk("n irq", n_irq, 32'h0);
    // ==========================================================
    // repeat, area 2, fixed source, read skip, slow memory
    slow = 1'b1;
    watch = 32'h0000_0040;
    desc(4, 32'h0000_1909, 32'h0000_0104, 32'h0000_01a0, 32'h0005_0202);
    for (int i = 1; i <= 3; i++)
    begin
      far.m[65] = 32'h0000_0010 + i;
      fire(4);
    end
    chk("r wrap", far.m[104], 32'h0000_0013);
    chk("r 2nd", far.m[105], 32'h0000_0012);
    chk("r dst", far.m[18], 32'h0000_01a4);
    chk("r reads", n_rd0, 32'h1);
    chk("r src wb", n_wsrc, 32'h0);
    slow = 1'b0;
    // ==========================================================
    // block of 4 longwords, total reaches zero
    desc(2, 32'h0000_118a, 32'h0000_0120, 32'h0000_0140, 32'h0001_0404);
    for (int i = 0; i < 4; i++) far.m[72+i] = 32'hb000_0000 + i;
    fire(2);
    for (int i = 0; i < 4; i++)
      chk("b data", far.m[80+i], 32'hb000_0000 + i);
    chk("b ev", n_ev, 32'h1);
    chk("b irq", n_irq, 32'h1);
    chk("b en", en[2], 1'b0);
    // ==========================================================
    // chain to a byte transfer in short address mode
    desc(5, 32'h0000_0198, 32'h0000_0130, 32'h0000_0150, 32'h0003_0000);
    desc(6, 32'h0000_0200, 32'h00ff_fff3, 32'h0000_01c1, 32'h0003_0000);
    far.m[76] = 32'h1234_5678;
    far.m[124] = 32'h5a00_0000;
    fire(5);
    chk("c long", far.m[84], 32'h1234_5678);
    chk("c byte", far.m[112], 32'h0000_5a00);
    chk("c short", seen_hi, 1'b1);
    chk("c ev", n_ev, 32'h2);
    chk("c clr", n_clr, 32'h1);
    // ==========================================================
    // word in full address mode to the cpu, chain held off by count
    desc(7, 32'h0000_0434, 32'h00ff_ffe2, 32'h0000_01e4, 32'h0002_0000);
    far.m[120] = 32'hbeef_0000;
    fire(7);
    chk("p word", far.m[121], 32'h0000_beef);
    chk("p full", seen_full, 1'b1);
    chk("p irq", n_irq, 32'h1);
    chk("p ev", n_ev, 32'h1);
    chk("p en", en[7], 1'b0);
    chk("p src", act_src, 32'h7);
    // same channel again, interrupt after each unit only
    far.m[28] = 32'h0000_0044;
    far.m[31] = 32'h0003_0000;
    far.m[120] = 32'hcafe_0000;
    @(posedge ref_clk);
    en[7] <= 1'b1;
    fire(7);
    chk("e word", far.m[121], 32'h0000_cafe);
    chk("e irq", n_irq, 32'h1);
    chk("e clr", n_clr, 32'h0);
    end_of_test();
  end
endmodule : test_interrupt_triggered_transfer_unit
